// ---- rtl/swb_core.sv ----
`timescale 1ns/100ps
`include "swb_consts.svh"
module swb_core
    import swb_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        instr_valid,
    input  wire logic [15:0] instr_word,
    input  wire logic        ext_set_enable,
    input  wire logic [3:0]  bank_pointer_register,
    input  wire logic [11:0] index_base,
    input  wire logic [7:0]  mem_rdata,
    input  wire logic [7:0]  w_load_data,
    input  wire logic        w_load,
    input  wire swb_flags_t  flags_load_data,
    input  wire logic        flags_load,
    output logic [11:0]      mem_raddr,
    output swb_mem_wr_t      mem_wr,
    output logic [7:0]       work_reg,
    output swb_flags_t       status,
    output logic             instr_done,
    output logic             instr_illegal,
    output swb_addr_mode_t   addr_mode
);
    // Instruction fields, sliced once so every user sees the same bits
    logic [5:0]  opc_field;
    logic        dest_reg;
    logic        bank_sel;
    logic [7:0]  reg_field;

    assign opc_field = instr_word[`SWB_OPC_HI:`SWB_OPC_LO];
    assign dest_reg  = instr_word[`SWB_DEST_BIT];
    assign bank_sel  = instr_word[`SWB_BANK_BIT];
    assign reg_field = instr_word[7:0];

    // Opcode match; any other valid word is flagged, never executed
    logic        opc_match;
    logic        is_sub_op;
    logic        is_foreign;

    assign opc_match  = (opc_field == `SWB_OPCODE);
    assign is_sub_op  = instr_valid && opc_match;
    assign is_foreign = instr_valid && !opc_match;

    // Destination split; dest bit clear writes W, dest bit set writes the register
    logic        to_reg;
    logic        to_work;

    assign to_reg  = is_sub_op && dest_reg;
    assign to_work = is_sub_op && !dest_reg;

    // Addressing mode qualifiers
    logic        low_operand;
    logic        use_index;
    logic        use_bank;
    logic        access_low;

    assign low_operand = (reg_field <= `SWB_INDEX_LIMIT);
    assign use_index   = ext_set_enable && !bank_sel
                         && low_operand;
    assign use_bank    = bank_sel;
    assign access_low  = (reg_field < `SWB_ACCESS_SPLIT);

    // Candidate addresses, one per mode
    // The indexed sum wraps at 12 bits; software keeps the base in range
    logic [11:0] index_addr;
    logic [11:0] bank_addr;
    logic [11:0] access_addr;

    assign index_addr  = 12'(index_base + {4'h0, reg_field});
    assign bank_addr   = {bank_pointer_register, reg_field};
    assign access_addr = access_low ? {4'h0, reg_field}
                                    : {`SWB_SFR_BANK, reg_field};

    // Mode code and final address; indexed mode overrides the access bank
    swb_addr_mode_t next_mode;
    logic [11:0]    next_addr;

    assign next_mode = use_index ? SWB_MODE_INDEXED
                     : use_bank  ? SWB_MODE_BANKED
                     : SWB_MODE_ACCESS;
    assign next_addr = use_index ? index_addr
                     : use_bank  ? bank_addr
                     : access_addr;

    // The read address stays combinational: the operand must return
    // within the issue cycle, or the op could not finish in one cycle
    assign mem_raddr = next_addr;

    // Arithmetic on the fetched operand with the current carry
    logic [7:0] diff;
    swb_flags_t new_flags;

    swb_subtract swb_subtract_inst (
        .minuend    (mem_rdata),
        .subtrahend (work_reg),
        .carry_in   (status.carry),
        .difference (diff),
        .flags      (new_flags)
    );

    // Next working register: a W-destination op beats an external load,
    // so a same-cycle load is lost rather than corrupting the result
    logic [7:0] next_work;

    assign next_work = to_work ? diff
                     : w_load  ? w_load_data
                     : work_reg;

    // Next status: every executed op rewrites all five flags
    swb_flags_t next_status;

    assign next_status = is_sub_op  ? new_flags
                       : flags_load ? flags_load_data
                       : status;

    // Next write request; idle fields held at zero for easy tracing
    swb_mem_wr_t next_wr;

    assign next_wr.write = to_reg;
    assign next_wr.addr  = is_sub_op ? next_addr : `SWB_ADDR_RESET;
    assign next_wr.data  = is_sub_op ? diff : 8'h00;

    // Completion and refusal pulses
    logic next_done;
    logic next_illegal;

    assign next_done    = is_sub_op;
    assign next_illegal = is_foreign;

    // Mode of the last executed op, back to access when idle
    swb_addr_mode_t next_mode_out;

    assign next_mode_out = is_sub_op ? next_mode : SWB_MODE_ACCESS;

    // Working register
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            work_reg <= `SWB_W_RESET;
        end else begin
            work_reg <= next_work;
        end
    end

    // Status flags
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            status <= `SWB_STATUS_RESET;
        end else begin
            status <= next_status;
        end
    end

    // Write-back request, a one-cycle pulse
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mem_wr <= '0;
        end else begin
            mem_wr <= next_wr;
        end
    end

    // Completion pulse
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            instr_done <= 1'b0;
        end else begin
            instr_done <= next_done;
        end
    end

    // Refusal pulse
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            instr_illegal <= 1'b0;
        end else begin
            instr_illegal <= next_illegal;
        end
    end

    // Addressing mode report
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            addr_mode <= SWB_MODE_ACCESS;
        end else begin
            addr_mode <= next_mode_out;
        end
    end

endmodule // swb_core

// ---- rtl/swb_consts.svh ----
// Function
// - Compute f minus W minus borrow, set flags
// - Destination bit picks W or register
// - Bank bit picks access bank or bank pointer
// - Extended set, low operand with bank bit clear uses indexed offset
`ifndef SWB_CONSTS_SVH
`define SWB_CONSTS_SVH
`define SWB_OPCODE        6'h16
`define SWB_OPC_HI        15
`define SWB_OPC_LO        10
`define SWB_DEST_BIT      9
`define SWB_BANK_BIT      8
`define SWB_INDEX_LIMIT   8'h5F
`define SWB_ACCESS_SPLIT  8'h60
`define SWB_SFR_BANK      4'hF
`define SWB_W_RESET       8'h00
`define SWB_STATUS_RESET  5'h00
`define SWB_ADDR_RESET    12'h000
`endif

// ---- rtl/swb_pkg.sv ----
package swb_pkg;
    // Flag group in status order: negative, range, zero, half, carry
    typedef struct packed {
        logic negative;
        logic signed_range_flag;
        logic zero;
        logic half_carry_flag;
        logic carry;
    } swb_flags_t;

    // One data-memory write request
    typedef struct packed {
        logic        write;
        logic [11:0] addr;
        logic [7:0]  data;
    } swb_mem_wr_t;

    typedef enum logic [1:0] {
        SWB_MODE_ACCESS  = 2'b00,
        SWB_MODE_BANKED  = 2'b01,
        SWB_MODE_INDEXED = 2'b10
    } swb_addr_mode_t;
endpackage

// ---- rtl/swb_subtract.sv ----
`timescale 1ns/100ps
`include "swb_consts.svh"
module swb_subtract
    import swb_pkg::*;
(
    input  wire logic [7:0] minuend,
    input  wire logic [7:0] subtrahend,
    input  wire logic       carry_in,
    output logic      [7:0] difference,
    output swb_flags_t      flags
);
    // Subtract as f + ~W + C; carry out is the inverted borrow
    logic [8:0] full_sum;
    logic [4:0] low_sum;
    assign full_sum   = {1'b0, minuend} + {1'b0, ~subtrahend}
                        + {8'h00, carry_in};
    assign low_sum    = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]}
                        + {4'h0, carry_in};
    assign difference = full_sum[7:0];

    // Flags derived from the sum
    assign flags.carry             = full_sum[8];
    assign flags.half_carry_flag   = low_sum[4];
    assign flags.negative          = full_sum[7];
    assign flags.zero              = (full_sum[7:0] == 8'h00);
    assign flags.signed_range_flag = (minuend[7] != subtrahend[7])
                                     && (full_sum[7] != minuend[7]);
endmodule // swb_subtract

// ---- tb/swb_core_asserts.sv ----
`timescale 1ns/100ps
module swb_core_asserts
    import swb_pkg::*;
(
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic        instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic        ext_set_enable,
    input wire logic [3:0]  bank_pointer_register,
    input wire logic [11:0] index_base,
    input wire logic [7:0]  mem_rdata,
    input wire logic [11:0] mem_raddr,
    input wire swb_mem_wr_t mem_wr,
    input wire logic [7:0]  work_reg,
    input wire swb_flags_t  status,
    input wire logic        instr_done,
    input wire logic        instr_illegal
);
    // Reference result built from live operands, compared one edge later
    wire logic [7:0] exp_diff = mem_rdata + ~work_reg + {7'h00, status.carry};
    wire logic       op_hit   = instr_valid && instr_word[15:10] == 6'h16;
    wire logic       dest_bit = instr_word[9];
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence s_take; op_hit; endsequence
    sequence s_to_reg; s_take ##0 dest_bit; endsequence
    sequence s_to_w; s_take ##0 !dest_bit; endsequence
    AST_DONE: assert property (s_take |=> instr_done)
        else $error("op not completed in one cycle");
    AST_REG_DATA: assert property (s_to_reg |=>
        mem_wr.data == $past(exp_diff))
        else $error("register result wrong");
    AST_W_DATA: assert property (s_to_w |=>
        work_reg == $past(exp_diff))
        else $error("working register result wrong");
    AST_WRITE: assert property (s_take |=>
        mem_wr.write == $past(dest_bit))
        else $error("write strobe does not follow dest bit");
    AST_BANK: assert property (s_take ##0 instr_word[8] |->
        mem_raddr == {bank_pointer_register, instr_word[7:0]})
        else $error("banked address wrong");
    AST_ACCESS_HI: assert property (s_take ##0 (!instr_word[8]
        && instr_word[7:0] >= 8'h60) |-> mem_raddr == {4'hF, instr_word[7:0]})
        else $error("upper access bank address wrong");
    AST_INDEX: assert property (s_take ##0 (ext_set_enable
        && !instr_word[8] && instr_word[7:0] <= 8'h5F)
        |-> mem_raddr == index_base + instr_word[7:0])
        else $error("indexed address wrong");
    AST_ZERO: assert property (s_take |=>
        status.zero == ($past(exp_diff) == 8'h00))
        else $error("zero flag wrong");
    AST_REFUSE: assert property (instr_valid && !op_hit |=>
        instr_illegal && !instr_done)
        else $error("foreign word not refused");
endmodule // swb_core_asserts
bind swb_core swb_core_asserts swb_core_asserts_inst (.clock, .sys_rst,
    .instr_valid, .instr_word, .ext_set_enable, .bank_pointer_register,
    .index_base, .mem_rdata, .mem_raddr, .mem_wr, .work_reg, .status,
    .instr_done, .instr_illegal);

// ---- tb/swb_core_test.sv ----
`timescale 1ns/100ps
module swb_core_test;
    import swb_pkg::*;
    logic clock = 0, sys_rst = 1, instr_valid = 0, ext_set_enable = 0;
    logic w_load = 0, flags_load = 0, instr_done, instr_illegal;
    logic [15:0] instr_word = 16'h0000;
    logic [3:0] bank_pointer_register = 4'h3;
    logic [11:0] index_base = 12'h200, mem_raddr;
    logic [7:0] mem_rdata = 8'h00, w_load_data = 8'h00, work_reg, w, dv;
    swb_flags_t flags_load_data = 5'h00, status, st;
    swb_mem_wr_t mem_wr;
    swb_addr_mode_t addr_mode;
    logic [8:0] s;
    int err_count = 0, comparisons = 0;
    // Free-running core clock
    always #4 clock = ~clock;
    swb_core swb_core_inst (.clock, .sys_rst, .instr_valid, .instr_word,
        .ext_set_enable, .bank_pointer_register, .index_base, .mem_rdata,
        .w_load_data, .w_load, .flags_load_data, .flags_load, .mem_raddr,
        .mem_wr, .work_reg, .status, .instr_done, .instr_illegal, .addr_mode);
    task check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            err_count++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task conclude;
        $display("comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Preload W and carry through the external load ports
    task preload(input logic [7:0] wv, input logic c);
        @(negedge clock) {w_load, w_load_data, flags_load} = {1'b1, wv, 1'b1};
        flags_load_data = {4'h0, c};
        @(negedge clock) {w_load, flags_load} = 2'b00;
        {w, st} = {wv, 4'h0, c};
    endtask
    // One op: expected flags from f + ~W + C, borrow is the carry inverted
    task run(input logic d, a, input logic [7:0] f, rv, input logic [11:0] ea,
             input swb_addr_mode_t md);
        @(negedge clock) {instr_valid, instr_word} = {1'b1, 6'h16, d, a, f};
        mem_rdata = rv;
        #1 check(mem_raddr, ea);
        s = {1'b0, rv[3:0]} + {1'b0, ~w[3:0]} + st.carry;
        st.half_carry_flag = s[4];
        s = {1'b0, rv} + {1'b0, ~w} + st.carry;
        dv = s[7:0];
        {st.negative, st.zero, st.carry} = {dv[7], dv == 8'h00, s[8]};
        st.signed_range_flag = (rv[7] ^ w[7]) & (dv[7] ^ rv[7]);
        if (!d) w = dv;
        @(negedge clock) instr_valid = 0;
        check({instr_illegal, instr_done, addr_mode, status},
              {1'b0, 1'b1, md, st});
        check({mem_wr.write, work_reg}, {d, w});
        if (d) check({mem_wr.addr, mem_wr.data}, {ea, dv});
    endtask
    task t_examples;
        preload(8'h0D, 1'b1);
        run(1, 0, 8'h19, 8'h19, 12'h019, SWB_MODE_ACCESS);
        preload(8'h1A, 1'b0);
        run(0, 0, 8'h1B, 8'h1B, 12'h01B, SWB_MODE_ACCESS);
        preload(8'h0E, 1'b1);
        run(1, 0, 8'h03, 8'h03, 12'h003, SWB_MODE_ACCESS);
        run(0, 0, 8'h80, 8'h80, 12'hF80, SWB_MODE_ACCESS);
    endtask
    task t_modes;
        run(1, 1, 8'h42, 8'h7F, 12'h342, SWB_MODE_BANKED);
        ext_set_enable = 1;
        run(0, 0, 8'h5F, 8'h10, 12'h25F, SWB_MODE_INDEXED);
        run(1, 0, 8'h60, 8'hA5, 12'hF60, SWB_MODE_ACCESS);
    endtask
    // A subtract without borrow must be refused
    task t_refuse;
        @(negedge clock) {instr_valid, instr_word} = {1'b1, 16'h5C05};
        @(negedge clock) instr_valid = 0;
        check({instr_illegal, instr_done, mem_wr.write}, 3'h4);
    endtask
    initial begin
        repeat (5) @(negedge clock);
        sys_rst = 0;
        t_examples;
        t_modes;
        t_refuse;
        conclude;
    end
    initial begin
        #50000 err_count++;
        conclude;
    end
endmodule // swb_core_test
